// *** rtl/lfc_regs.svh ***
// lfc_regs.svh: constants of the loopback frame check block
`ifndef LFC_REGS_SVH
`define LFC_REGS_SVH
`define LFC_CRC_PRESET 16'hFFFF
`define LFC_CRC_POLY   16'hA001
`define LFC_FUNC_LOOP  8'h08
`define LFC_FOLD_STEPS 4'h8
`define LFC_DATA_LEN   4'h6
`define LFC_LAST_IDX   4'h7
`define LFC_POS_ADDR   3'h0
`define LFC_POS_FUNC   3'h1
`define LFC_POS_CHK_LO 3'h6
`define LFC_POS_CHK_HI 3'h7
`endif

// *** rtl/lfc_pkg.sv ***
// lfc_pkg: types of the loopback frame check block
`default_nettype none
package lfc_pkg;
    typedef enum logic [2:0] {
        ST_RECV  = 3'b000,
        ST_FOLD  = 3'b001,
        ST_CHECK = 3'b010,
        ST_EMIT  = 3'b011,
        ST_EFOLD = 3'b100
    } lfc_state_type;
endpackage : lfc_pkg
`default_nettype wire

// *** rtl/lfc_crc_if.sv ***
// lfc_crc_if: carrier between the frame controller and the check engine
`timescale 1ns/1ns
`default_nettype none
interface lfc_crc_if;
    logic        start;
    logic        init;
    logic [7:0]  data;
    logic        busy;
    logic [15:0] value;
    modport engine (input start, input init, input data, output busy, output value);
    modport user   (output start, output init, output data, input busy, input value);
endinterface : lfc_crc_if
`default_nettype wire

// *** rtl/lfc_crc.sv ***
// lfc_crc: bit-serial 16-bit frame check engine, one byte per nine cycles (load, then eight shifts)
`timescale 1ns/1ns
`default_nettype none
`include "lfc_regs.svh"
module lfc_crc import lfc_pkg::*; (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // fold requests
    lfc_crc_if.engine crc
);
    logic [15:0] value;
    logic [15:0] next_value;
    logic [3:0]  cnt;
    logic [3:0]  next_cnt;
    logic        busy;
    logic        next_busy;

    // one shift per busy cycle; a start while busy is ignored
    always_comb begin
        next_value = value;
        next_cnt   = cnt;
        next_busy  = busy;
        if (busy) begin
            next_value = {1'b0, value[15:1]} ^ (value[0] ? `LFC_CRC_POLY : 16'h0000);
            next_cnt   = cnt - 4'h1;
            next_busy  = (cnt != 4'h1);
        end else if (crc.start) begin
            next_value = (crc.init ? `LFC_CRC_PRESET : value) ^ {8'h00, crc.data};
            next_cnt   = `LFC_FOLD_STEPS;
            next_busy  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            value <= `LFC_CRC_PRESET;
            cnt   <= 4'h0;
            busy  <= 1'b0;
        end else begin
            value <= next_value;
            cnt   <= next_cnt;
            busy  <= next_busy;
        end
    end

    assign crc.value = value;
    assign crc.busy  = busy;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_fold;
        busy [*8] ##1 !busy;
    endsequence

    a_fold_eight: assert property (!busy && crc.start |=> s_fold)
        else $error("fold did not take eight steps");
    a_preset_fold: assert property (!busy && crc.start && crc.init
            |=> value == (`LFC_CRC_PRESET ^ {8'h00, $past(crc.data)}))
        else $error("preset xor byte wrong");
    a_shift_poly: assert property (busy && value[0]
            |=> value == ({1'b0, $past(value[15:1])} ^ `LFC_CRC_POLY))
        else $error("odd step missed polynomial");
    a_zero_fill: assert property (busy && !value[0] |=> !value[15])
        else $error("shift did not fill zero");
endmodule : lfc_crc
`default_nettype wire

// *** rtl/lfc_fifo.sv ***
// lfc_fifo: reply byte buffer with registered read side
`timescale 1ns/1ns
`default_nettype none
module lfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             next_out_valid;
    logic             push;
    logic             pop;

    // pop refills the output register when it is empty or taken and a byte is stored
    always_comb begin
        push           = in_valid && in_ready;
        pop            = (count != '0) && (!out_valid || out_ready);
        next_wr_ptr    = wr_ptr + AW'(push);
        next_rd_ptr    = rd_ptr + AW'(pop);
        next_count     = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_out_valid = pop || (out_valid && !out_ready);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            in_ready  <= 1'b1;
        end else begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            out_valid <= next_out_valid;
            in_ready  <= (next_count != FULL_CNT);
        end
    end

    // storage and read register carry no reset, only data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
        if (pop) begin
            out_data <= mem[rd_ptr];
        end
    end
endmodule : lfc_fifo
`default_nettype wire

// *** rtl/lfc_top.sv ***
// lfc_top: loop-detection frame responder with 16-bit frame check
// How it works
// - reply carries function code 08h in its second byte.
// - reply starts with our own station address.
// - four test bytes are echoed unchanged, in order, as bytes three to six.
// - check register presets to FFFFh; each byte is xored into low bits.
// - per step, shift right, then xor A001h when bit 0 was one.
// - every right shift brings a zero into the top bit.
// - exactly eight shift steps per byte before the next byte.
// - first six bytes fold in order; result is the frame check.
// - seventh byte is check low half, eighth is check high half.
`timescale 1ns/1ns
`default_nettype none
`include "lfc_regs.svh"
module lfc_top import lfc_pkg::*; #(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // station identity
    input  wire logic [7:0] own_addr,
    // request byte stream
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_valid,
    output logic            rx_ready,
    // reply byte stream
    output logic [7:0]      tx_data,
    output logic            tx_valid,
    input  wire logic       tx_ready,
    // frame outcome pulses
    output logic            frame_good,
    output logic            frame_drop
);
    lfc_state_type state;
    lfc_state_type next_state;
    logic [3:0]    idx;
    logic [3:0]    next_idx;
    logic [7:0]    frame [8];
    logic [7:0]    next_frame [8];
    logic          next_rx_ready;
    logic          next_good;
    logic          next_drop;
    logic          frame_match;
    logic          push_valid;
    logic          push_ready;
    logic [7:0]    push_data;
    logic          addr_match;
    logic          code_match;
    logic          check_match;
    logic [3:0]    fold_cnt;
    logic [3:0]    next_fold_cnt;

    lfc_crc_if crc ();

    // check engine shared by the receive and the reply pass
    lfc_crc u_crc (
        .clk     (clk),
        .sys_rst (sys_rst),
        .crc     (crc.engine)
    );

    // reply buffer; a stalled drain holds the controller in emit
    lfc_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_data   (push_data),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .out_data  (tx_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    // frame acceptance test, seen only in the check state; the three parts are
    // kept apart so that each way of dropping a frame can be checked on its own
    always_comb begin
        addr_match  = (frame[`LFC_POS_ADDR] == own_addr);
        code_match  = (frame[`LFC_POS_FUNC] == `LFC_FUNC_LOOP);
        check_match = (frame[`LFC_POS_CHK_LO] == crc.value[7:0])
                   && (frame[`LFC_POS_CHK_HI] == crc.value[15:8]);
        frame_match = addr_match && code_match && check_match;
    end

    // reply byte for the current position
    always_comb begin
        case (idx[2:0])
            `LFC_POS_ADDR:   push_data = own_addr;
            `LFC_POS_FUNC:   push_data = `LFC_FUNC_LOOP;
            `LFC_POS_CHK_LO: push_data = crc.value[7:0];
            `LFC_POS_CHK_HI: push_data = crc.value[15:8];
            default:         push_data = frame[idx[2:0]];
        endcase
    end

    // frame controller: receive, fold, check, then emit the reply
    always_comb begin
        next_state = state;
        next_idx   = idx;
        next_frame = frame;
        next_good  = 1'b0;
        next_drop  = 1'b0;
        crc.start  = 1'b0;
        crc.init   = 1'b0;
        crc.data   = 8'h00;
        push_valid = 1'b0;
        case (state)
            ST_RECV: begin
                if (rx_valid && rx_ready) begin
                    next_frame[idx[2:0]] = rx_data;
                    if (idx < `LFC_DATA_LEN) begin
                        crc.start  = 1'b1;
                        crc.init   = (idx == 4'h0);
                        crc.data   = rx_data;
                        next_state = ST_FOLD;
                    end else if (idx == `LFC_LAST_IDX) begin
                        next_state = ST_CHECK;
                    end else begin
                        next_idx = idx + 4'h1;
                    end
                end
            end
            ST_FOLD: begin
                if (!crc.busy) begin
                    next_idx   = idx + 4'h1;
                    next_state = ST_RECV;
                end
            end
            ST_CHECK: begin
                next_idx = 4'h0;
                if (frame_match) begin
                    next_state = ST_EMIT;
                end else begin
                    next_state = ST_RECV;
                    next_drop  = 1'b1;
                end
            end
            ST_EMIT: begin
                push_valid = 1'b1;
                if (push_ready) begin
                    if (idx < `LFC_DATA_LEN) begin
                        crc.start  = 1'b1;
                        crc.init   = (idx == 4'h0);
                        crc.data   = push_data;
                        next_state = ST_EFOLD;
                    end else if (idx == `LFC_LAST_IDX) begin
                        next_idx   = 4'h0;
                        next_state = ST_RECV;
                        next_good  = 1'b1;
                    end else begin
                        next_idx = idx + 4'h1;
                    end
                end
            end
            ST_EFOLD: begin
                if (!crc.busy) begin
                    next_idx   = idx + 4'h1;
                    next_state = ST_EMIT;
                end
            end
            default: begin
                next_state = ST_RECV;
                next_idx   = 4'h0;
            end
        endcase
        // requests are refused while a frame is checked or answered
        next_rx_ready = (next_state == ST_RECV);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state      <= ST_RECV;
            idx        <= 4'h0;
            rx_ready   <= 1'b0;
            frame_good <= 1'b0;
            frame_drop <= 1'b0;
        end else begin
            state      <= next_state;
            idx        <= next_idx;
            rx_ready   <= next_rx_ready;
            frame_good <= next_good;
            frame_drop <= next_drop;
        end
    end

    // received bytes are data only, no reset needed
    always_ff @(posedge clk) begin
        frame <= next_frame;
    end

    // helper: folds since the last preset, read only by the checks below;
    // counting requests, not shifts, lets one check cover both passes
    always_comb begin
        next_fold_cnt = fold_cnt;
        if (crc.start) begin
            next_fold_cnt = crc.init ? 4'h1 : fold_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fold_cnt <= 4'h0;
        end else begin
            fold_cnt <= next_fold_cnt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_push(logic [3:0] pos);
        state == ST_EMIT && push_ready && idx == pos;
    endsequence

    sequence s_take(logic [3:0] pos);
        state == ST_RECV && rx_valid && rx_ready && idx == pos;
    endsequence

    // a byte that starts a fold of the check register
    sequence s_fold_take;
        state == ST_RECV && rx_valid && rx_ready && idx < `LFC_DATA_LEN;
    endsequence

    // eight busy steps plus the return cycle, then the next byte is welcome
    sequence s_fold_pause;
        !rx_ready [*8] ##1 !rx_ready ##1 rx_ready;
    endsequence

    a_addr_reply: assert property (s_push(4'h0)
            |-> push_valid && push_data == own_addr && crc.init)
        else $error("reply address byte wrong");
    a_func_reply: assert property (s_push(4'h1)
            |-> push_data == `LFC_FUNC_LOOP ##1 state == ST_EFOLD)
        else $error("reply function code wrong");
    a_test_echo: assert property (s_take(4'h2) or s_take(4'h3)
            or s_take(4'h4) or s_take(4'h5)
            |=> frame[$past(idx[2:0])] == $past(rx_data))
        else $error("test byte not kept");
    a_six_folds: assert property ((state == ST_CHECK) or s_push(4'h6)
            |-> fold_cnt == 4'h6 && !crc.busy)
        else $error("check not over six bytes");
    a_check_tail: assert property (s_push(4'h6)
            |-> push_data == crc.value[7:0]
            ##1 state == ST_EMIT && push_data == crc.value[15:8])
        else $error("check bytes misordered");
    a_drop_bad: assert property (state == ST_CHECK && !frame_match
            |=> frame_drop && state == ST_RECV
            ##1 !frame_good && !push_valid)
        else $error("bad frame not dropped");
    a_rx_refused: assert property (state != ST_RECV |-> !rx_ready)
        else $error("request taken while busy");

    // pacing and reply checks; the sink may stall the reply at any time
    a_fold_pause: assert property (s_fold_take |=> s_fold_pause)
        else $error("request not paused for the fold");
    a_fold_resume: assert property (state == ST_FOLD && !crc.busy
            |=> state == ST_RECV && idx == $past(idx) + 4'h1)
        else $error("fold did not move to the next byte");
    a_reply_echo: assert property (state == ST_EMIT && idx >= 4'h2 && idx <= 4'h5
            |-> push_data == frame[idx[2:0]])
        else $error("test byte not echoed");
    a_emit_stall: assert property (state == ST_EMIT && !push_ready
            |=> state == ST_EMIT && $stable(idx))
        else $error("reply byte skipped on full buffer");
    a_reply_hold: assert property (tx_valid && !tx_ready
            |=> tx_valid && $stable(tx_data))
        else $error("reply byte changed while stalled");
    a_good_pulse: assert property (s_push(4'h7)
            |=> frame_good && state == ST_RECV ##1 !frame_good)
        else $error("reply end not flagged once");
    a_accept_emit: assert property (state == ST_CHECK && frame_match
            |=> state == ST_EMIT && idx == 4'h0 && !frame_drop)
        else $error("accepted frame not answered");
    a_check_once: assert property (state == ST_CHECK
            |=> state == ST_RECV || state == ST_EMIT)
        else $error("check state held too long");
    a_foreign_drop: assert property (state == ST_CHECK && !addr_match
            |=> frame_drop && state == ST_RECV)
        else $error("foreign frame answered");
    a_code_drop: assert property (state == ST_CHECK && !code_match
            |=> frame_drop && state == ST_RECV)
        else $error("other function code answered");
    a_check_drop: assert property (state == ST_CHECK && !check_match
            |=> frame_drop && state == ST_RECV)
        else $error("frame with bad check answered");
endmodule : lfc_top
`default_nettype wire

// *** test/lfc_host_model.sv ***
// lfc_host_model: serial master model that sends request bytes and sinks replies
`timescale 1ns/1ns
`default_nettype none
module lfc_host_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // request stream toward the device
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    // reply stream from the device
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    int         stall_pct = 0;
    int         seed      = 78477;
    logic [7:0] send_q[$];
    logic [7:0] got_q[$];
    logic       rx_hit    = 1'b0;
    logic       tx_hit    = 1'b0;
    logic [7:0] tx_seen   = 8'h00;

    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end

    // handshakes are sampled before the device's own edge updates land
    always @(posedge clk) begin
        rx_hit  <= rx_valid & rx_ready;
        tx_hit  <= tx_valid & tx_ready;
        tx_seen <= tx_data;
    end

    // bytes sent in order
    // a byte is held until the edge that takes it, then the next one follows
    always @(negedge clk) begin
        if (tx_hit)
            got_q.push_back(tx_seen);
        if (rx_hit && send_q.size() > 0)
            send_q.pop_front();
        if (!sys_rst && send_q.size() > 0) begin
            rx_valid = 1'b1;
            rx_data  = send_q[0];
        end else begin
            rx_valid = 1'b0;
            rx_data  = ~rx_data;    // idle line must not look like the last byte
        end
        tx_ready = ($unsigned($random(seed)) % 100) >= stall_pct;
    end
endmodule : lfc_host_model
`default_nettype wire

// *** test/testbench.sv ***
// testbench: loop-detection responder against a queue-based reference
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic       clk      = 1'b0;
    logic       sys_rst  = 1'b1;
    logic [7:0] own_addr = 8'h00;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       rx_ready;
    logic [7:0] tx_data;
    logic       tx_valid;
    logic       tx_ready;
    logic       frame_good;
    logic       frame_drop;
    int         num_errors  = 0;
    int         checks_done = 0;
    int         seed        = 78477;
    int         cycles      = 0;
    int         goods       = 0;
    int         drops       = 0;
    int         exp_good    = 0;
    int         exp_drop    = 0;
    logic [7:0] exp_q[$];

    always #4 clk = ~clk;

    lfc_top #(.FIFO_DEPTH(16)) dut_u (.clk(clk), .sys_rst(sys_rst), .own_addr(own_addr),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .frame_good(frame_good),
        .frame_drop(frame_drop));

    lfc_host_model host_u (.clk(clk), .sys_rst(sys_rst), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready));

    // outcome pulses counted; a hang is cut short here
    always @(posedge clk) begin
        cycles++;
        if (!sys_rst && frame_good === 1'b1) goods++;
        if (!sys_rst && frame_drop === 1'b1) drops++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    function automatic int crc16(input int f[$]);
        int c;
        c = 16'hFFFF;
        foreach (f[i]) begin
            c = c ^ f[i];
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction : crc16

    task automatic check(input bit ok, input string what);
        checks_done++;
        if (!ok) begin
            num_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check

    // queue one request; crc_err flips check bits to spoil the frame
    task automatic send_frame(input logic [7:0] adr, input logic [7:0] fc,
                              input logic [31:0] tst, input logic [15:0] crc_err);
        int f[$];
        int c;
        f = {adr, fc, tst[31:24], tst[23:16], tst[15:8], tst[7:0]};
        c = crc16(f);
        foreach (f[i]) host_u.send_q.push_back(f[i][7:0]);
        host_u.send_q.push_back(c[7:0] ^ crc_err[7:0]);
        host_u.send_q.push_back(c[15:8] ^ crc_err[15:8]);
        // only clean frames for us with code 08h are answered
        if (crc_err == 16'h0000 && adr === own_addr && fc === 8'h08) begin
            exp_good++;
            foreach (f[i]) exp_q.push_back(f[i][7:0]);
            exp_q.push_back(c[7:0]);
            exp_q.push_back(c[15:8]);
        end else begin
            exp_drop++;
        end
    endtask : send_frame

    // wait for the traffic to settle, then compare everything seen
    task automatic drain();
        int n;
        n = 0;
        while ((host_u.send_q.size() != 0 || host_u.got_q.size() < exp_q.size()) && n < 6000) begin
            @(negedge clk);
            n++;
        end
        repeat (20) @(negedge clk);    // room for a late outcome pulse
        check(host_u.got_q.size() == exp_q.size(), "reply byte count");
        while (exp_q.size() > 0 && host_u.got_q.size() > 0)
            check(host_u.got_q.pop_front() === exp_q.pop_front(), "reply byte");
        check(goods == exp_good && drops == exp_drop, "outcome pulses");
        exp_q.delete();
        host_u.got_q.delete();
    endtask : drain

    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        own_addr = 8'h01;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        // worked example: check bytes 41h then 04h
        check(crc16({1, 8, 1, 2, 3, 4}) == 16'h0441, "reference example");
        send_frame(8'h01, 8'h08, 32'h0102_0304, 16'h0000);
        drain();
        // address range ends and random test bytes, sink stalling
        host_u.stall_pct = 40;
        for (int k = 0; k < 12; k++) begin
            own_addr = (k == 0) ? 8'h00 : (k == 1) ? 8'hFE : 8'($unsigned($random(seed)) % 255);
            send_frame(own_addr, 8'h08, $random(seed), 16'h0000);
            drain();
        end
        // spoiled, foreign and other-code frames back to back
        own_addr = 8'h5A;
        send_frame(8'h5A, 8'h08, $random(seed), 16'h0001);
        send_frame(8'h5A, 8'h08, $random(seed), 16'h8000);
        send_frame(8'h5B, 8'h08, $random(seed), 16'h0000);
        send_frame(8'h5A, 8'h06, $random(seed), 16'h0000);
        send_frame(8'h5A, 8'h08, 32'hFF00_00FF, 16'h0000);
        drain();
        // buffer fills while the sink refuses, third reply must wait
        host_u.stall_pct = 100;
        repeat (3) send_frame(8'h5A, 8'h08, $random(seed), 16'h0000);
        repeat (600) @(negedge clk);
        check(goods == exp_good - 1 && rx_ready === 1'b0, "emit stalls on full buffer");
        check(tx_valid === 1'b1 && host_u.got_q.size() == 0, "reply held while stalled");
        host_u.stall_pct = 0;
        drain();
        // reset in mid-frame, then a clean frame
        host_u.send_q = {8'h5A, 8'h08, 8'h11};
        repeat (40) @(negedge clk);
        sys_rst = 1'b1;
        host_u.send_q.delete();
        repeat (2) @(negedge clk);
        check({rx_ready, tx_valid, frame_good, frame_drop} === 4'b0000, "reset outputs");
        sys_rst = 1'b0;
        send_frame(8'h5A, 8'h08, $random(seed), 16'h0000);
        drain();
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
